// file: core/cst_pkg.sv
package cst_pkg;
    // Register map, byte addresses on the APB side
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_OPTION = 8'h04;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
    // Core status bit positions
    localparam int ST_IRP = 7;
    localparam int ST_RP_HI = 6;
    localparam int ST_RP_LO = 5;
    localparam int ST_TO = 4;
    localparam int ST_PD = 3;
    localparam int ST_Z = 2;
    localparam int ST_DC = 1;
    localparam int ST_C = 0;
    localparam logic [7:0] STATUS_RESET = 8'h18;
    // Timer option register fields
    localparam int OPT_PSA = 3;
    localparam int OPT_PS_HI = 2;
    localparam int OPT_PS_LO = 0;
    localparam logic [3:0] OPTION_RESET = 4'hf;
    // Interrupt status bits
    localparam int IRQ_W = 3;
    localparam int IRQ_WDT = 0;
    localparam int IRQ_OST = 1;
    localparam int IRQ_WAKE = 2;
    // Oscillator selection codes
    localparam logic [2:0] CLK_CRYSTAL_LOW = 3'h0;
    localparam logic [2:0] CLK_CRYSTAL_MEDIUM = 3'h1;
    localparam logic [2:0] CLK_CRYSTAL_HIGH = 3'h2;
    // Start-up timer length in oscillator cycles
    localparam int OST_CYCLES = 1024;
    localparam int OST_W = 11;
    localparam int WDT_BASE_DEFAULT = 2048;
    typedef enum logic [3:0] {
        CST_OP_MOVE = 4'h0,
        CST_OP_ADD = 4'h1,
        CST_OP_SUB = 4'h2,
        CST_OP_ROR = 4'h3,
        CST_OP_ROL = 4'h4,
        CST_OP_AND = 4'h5,
        CST_OP_OR = 4'h6,
        CST_OP_XOR = 4'h7,
        CST_OP_CLEAR = 4'h8
    } cst_op_t;
    typedef enum logic [3:0] {
        PWR_BOOT = 4'b0001,
        PWR_RUN = 4'b0010,
        PWR_SLEEP = 4'b0100,
        PWR_OST = 4'b1000
    } cst_pwr_t;
endpackage : cst_pkg

// file: core/cst_alu.sv
`timescale 1ns/1ps
`default_nettype none
module cst_alu (
    input wire cst_pkg::cst_op_t op, // Operation
    input wire logic [7:0] operand_a, // File or literal operand
    input wire logic [7:0] operand_b, // Working register operand
    input wire logic carry_in, // Present carry flag
    output logic [7:0] result, // Operation result
    output logic zero, // Result is zero
    output logic digit_carry, // Carry out of bit 3
    output logic carry, // Carry out of bit 7 or shifted bit
    output logic upd_zero, // Operation updates zero flag
    output logic upd_dc, // Operation updates digit carry
    output logic upd_carry // Operation updates carry
);
    import cst_pkg::*;
    logic [8:0] sum;
    logic [4:0] nib;
    always_comb begin
        sum = {1'b0, operand_a} + {1'b0, operand_b};
        nib = {1'b0, operand_a[3:0]} + {1'b0, operand_b[3:0]};
        result = operand_a;
        carry = carry_in;
        digit_carry = 1'b0;
        upd_zero = 1'b0;
        upd_dc = 1'b0;
        upd_carry = 1'b0;
        case (op)
            CST_OP_ADD, CST_OP_SUB: begin
                if (op == CST_OP_SUB) begin
                    // Borrow shows as an inverted carry
                    sum = {1'b0, operand_a} + {1'b0, ~operand_b} + 9'h001;
                    nib = {1'b0, operand_a[3:0]} + {1'b0, ~operand_b[3:0]}
                        + 5'h01;
                end
                result = sum[7:0];
                carry = sum[8];
                digit_carry = nib[4];
                upd_zero = 1'b1;
                upd_dc = 1'b1;
                upd_carry = 1'b1;
            end
            CST_OP_ROR: begin
                result = {carry_in, operand_a[7:1]};
                carry = operand_a[0];
                upd_carry = 1'b1;
            end
            CST_OP_ROL: begin
                result = {operand_a[6:0], carry_in};
                carry = operand_a[7];
                upd_carry = 1'b1;
            end
            CST_OP_AND: begin
                result = operand_a & operand_b;
                upd_zero = 1'b1;
            end
            CST_OP_OR: begin
                result = operand_a | operand_b;
                upd_zero = 1'b1;
            end
            CST_OP_XOR: begin
                result = operand_a ^ operand_b;
                upd_zero = 1'b1;
            end
            CST_OP_CLEAR: begin
                result = 8'h00;
                upd_zero = 1'b1;
            end
            default: begin
                result = operand_a;
            end
        endcase
        zero = (result == 8'h00);
    end
endmodule : cst_alu
`default_nettype wire

// file: core/cst_wdt.sv
`timescale 1ns/1ps
`default_nettype none
module cst_wdt #(
    parameter int BASE_CYCLES = cst_pkg::WDT_BASE_DEFAULT
) (
    input wire logic clk, // Core clock
    input wire logic reset_n, // Async reset, active low
    input wire logic ce, // Clock enable
    input wire logic clear, // Hold counter cleared
    input wire logic prescaler_assign, // Postscaler on watchdog
    input wire logic [2:0] prescale_select, // Postscale ratio
    output logic timeout // One-cycle time-out pulse
);
    import cst_pkg::*;
    // BASE_CYCLES must be at least 2
    localparam int BW = $clog2(BASE_CYCLES);
    logic [BW-1:0] base_r;
    logic [7:0] post_r;
    logic [7:0] post_lim;
    logic tick;
    assign tick = (base_r == BW'(BASE_CYCLES - 1));
    // Ratio 1:1 unless the postscaler is given to the watchdog
    assign post_lim = prescaler_assign ?
        (8'h01 << prescale_select) - 8'h01 : 8'h00;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            base_r <= '0;
            post_r <= 8'h00;
            timeout <= 1'b0;
        end else if (ce) begin
            timeout <= 1'b0;
            if (clear) begin
                base_r <= '0;
                post_r <= 8'h00;
            end else if (tick) begin
                base_r <= '0;
                if (post_r == post_lim) begin
                    post_r <= 8'h00;
                    timeout <= 1'b1;
                end else begin
                    post_r <= post_r + 8'h01;
                end
            end else begin
                base_r <= base_r + BW'(1);
            end
        end
    end
endmodule : cst_wdt
`default_nettype wire

// file: core/cst_core_status.sv
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cst_core_status #(
    parameter int WDT_BASE_CYCLES = cst_pkg::WDT_BASE_DEFAULT
) (
    input wire logic clk, // Core clock
    input wire logic reset_n, // Async reset, active low
    input wire logic ce, // Clock enable
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic instr_valid, // Instruction executes
    input wire cst_pkg::cst_op_t instr_op, // Instruction operation
    input wire logic instr_dest_status, // Result goes to status
    input wire logic [7:0] operand_a, // File or literal operand
    input wire logic [7:0] operand_b, // Working register operand
    input wire logic watchdog_clear_instr, // Watchdog clear executes
    input wire logic sleep_instr, // Sleep executes
    input wire logic wake_event, // Wake request while asleep
    input wire logic watchdog_enable_cfg, // Configuration enable
    input wire logic [2:0] clock_mode, // Oscillator selection
    input wire logic secondary_osc, // System clock from secondary osc
    input wire logic [6:0] direct_addr_lo, // Direct address offset
    input wire logic [7:0] indirect_ptr, // Indirect pointer
    output logic [7:0] core_status, // Core status register
    output logic [7:0] alu_result, // Last operation result
    output logic [8:0] direct_addr, // Full direct address
    output logic [8:0] indirect_addr, // Full indirect address
    output logic core_released, // Core may execute
    output logic core_asleep, // Core is in sleep
    output logic irq // Interrupt request
);
    import cst_pkg::*;

    cst_pwr_t pwr_r;
    cst_pwr_t pwr_nxt;
    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic [3:0] option_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [IRQ_W-1:0] irq_event;
    logic [OST_W-1:0] ost_cnt_r;
    logic ost_done;
    logic crystal;
    logic running;
    logic instr_fire;
    logic clr_fire;
    logic sleep_fire;
    logic wake_fire;
    logic wdt_clear;
    logic wdt_timeout;
    logic [7:0] alu_res;
    logic alu_z;
    logic alu_dc;
    logic alu_c;
    logic upd_z;
    logic upd_dc;
    logic upd_c;
    logic upd_any;
    logic setup_ph;
    logic apb_wr;
    logic addr_ok;
    logic [31:0] rd_word;

    assign running = pwr_r == PWR_RUN;
    assign instr_fire = instr_valid & running;
    assign clr_fire = watchdog_clear_instr & running;
    assign sleep_fire = sleep_instr & running;
    assign wake_fire = (pwr_r == PWR_SLEEP) & (wake_event | wdt_timeout);
    assign crystal = ~secondary_osc & ((clock_mode == CLK_CRYSTAL_LOW)
        | (clock_mode == CLK_CRYSTAL_MEDIUM)
        | (clock_mode == CLK_CRYSTAL_HIGH));
    assign ost_done = (pwr_r == PWR_OST)
        & (ost_cnt_r == OST_W'(OST_CYCLES - 1));

    cst_alu u_alu (
        .op(instr_op),
        .operand_a(operand_a),
        .operand_b(operand_b),
        .carry_in(status_r[ST_C]),
        .result(alu_res),
        .zero(alu_z),
        .digit_carry(alu_dc),
        .carry(alu_c),
        .upd_zero(upd_z),
        .upd_dc(upd_dc),
        .upd_carry(upd_c)
    );
    assign upd_any = upd_z | upd_dc | upd_c;

    // Software has no path to stop an enabled watchdog
    assign wdt_clear = ~watchdog_enable_cfg
        | clr_fire
        | (wake_fire & ~crystal)
        | (pwr_r == PWR_OST)
        | (pwr_r == PWR_BOOT);

    cst_wdt #(
        .BASE_CYCLES(WDT_BASE_CYCLES)
    ) u_wdt (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .clear(wdt_clear),
        .prescaler_assign(option_r[OPT_PSA]),
        .prescale_select(option_r[OPT_PS_HI:OPT_PS_LO]),
        .timeout(wdt_timeout)
    );

    // Power sequencing; boot state samples the oscillator mode after reset
    always_comb begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            PWR_BOOT: begin
                pwr_nxt = crystal ? PWR_OST : PWR_RUN;
            end
            PWR_RUN: begin
                if (sleep_fire) begin
                    pwr_nxt = PWR_SLEEP;
                end
            end
            PWR_SLEEP: begin
                if (wake_fire) begin
                    pwr_nxt = crystal ? PWR_OST : PWR_RUN;
                end
            end
            PWR_OST: begin
                if (ost_done) begin
                    pwr_nxt = PWR_RUN;
                end
            end
            default: begin
                pwr_nxt = PWR_BOOT;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pwr_r <= PWR_BOOT;
        end else if (ce) begin
            pwr_r <= pwr_nxt;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ost_cnt_r <= '0;
        end else if (ce) begin
            if (pwr_r == PWR_OST) begin
                ost_cnt_r <= ost_cnt_r + OST_W'(1);
            end else begin
                ost_cnt_r <= '0;
            end
        end
    end

    // Status next value; the instruction path wins over an APB write
    always_comb begin
        status_nxt = status_r;
        if (instr_fire) begin
            if (instr_dest_status) begin
                status_nxt[ST_IRP] = alu_res[ST_IRP];
                status_nxt[ST_RP_HI:ST_RP_LO] =
                    alu_res[ST_RP_HI:ST_RP_LO];
                if (!upd_any) begin
                    status_nxt[ST_Z:ST_C] = alu_res[ST_Z:ST_C];
                end
            end
            // Written flag values are dropped when the operation updates any flag; flags it does not update keep their old value
            if (upd_z) begin
                status_nxt[ST_Z] = alu_z;
            end
            if (upd_dc) begin
                status_nxt[ST_DC] = alu_dc;
            end
            if (upd_c) begin
                status_nxt[ST_C] = alu_c;
            end
        end else if (apb_wr && paddr == OFF_STATUS) begin
            status_nxt[ST_IRP:ST_RP_LO] = pwdata[ST_IRP:ST_RP_LO];
            status_nxt[ST_Z:ST_C] = pwdata[ST_Z:ST_C];
        end
        // Reset-cause bits move only on internal events
        if (sleep_fire) begin
            status_nxt[ST_TO] = 1'b1;
            status_nxt[ST_PD] = 1'b0;
        end
        if (clr_fire) begin
            status_nxt[ST_TO] = 1'b1;
            status_nxt[ST_PD] = 1'b1;
        end
        if (wdt_timeout) begin
            status_nxt[ST_TO] = 1'b0;
        end
    end

    // Power-up leaves time-out and power-down set
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_r <= STATUS_RESET;
        end else if (ce) begin
            status_r <= status_nxt;
        end
    end
    assign core_status = status_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alu_result <= 8'h00;
        end else if (ce && instr_fire) begin
            alu_result <= alu_res;
        end
    end

    // Addresses follow the bank bits held after this edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            direct_addr <= 9'h000;
            indirect_addr <= 9'h000;
        end else if (ce) begin
            direct_addr <= {status_nxt[ST_RP_HI:ST_RP_LO],
                direct_addr_lo};
            indirect_addr <= {status_nxt[ST_IRP], indirect_ptr};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            core_released <= 1'b0;
            core_asleep <= 1'b0;
        end else if (ce) begin
            core_released <= pwr_nxt == PWR_RUN;
            core_asleep <= pwr_nxt == PWR_SLEEP;
        end
    end

    // APB slave: answers in the first access cycle, no wait states
    assign setup_ph = psel & ~penable;
    assign apb_wr = psel & penable & pready & pwrite & ~pslverr;
    assign addr_ok = (paddr == OFF_STATUS) | (paddr == OFF_OPTION)
        | (paddr == OFF_IRQ_STATUS) | (paddr == OFF_IRQ_MASK);

    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            OFF_STATUS: rd_word[7:0] = status_r;
            OFF_OPTION: rd_word[3:0] = option_r;
            OFF_IRQ_STATUS: rd_word[IRQ_W-1:0] = irq_stat_r;
            OFF_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask_r;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            pready <= setup_ph;
            pslverr <= setup_ph & ~addr_ok;
            if (setup_ph && !pwrite) begin
                prdata <= rd_word;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            option_r <= OPTION_RESET;
        end else if (ce && apb_wr && paddr == OFF_OPTION) begin
            option_r <= pwdata[3:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_mask_r <= '0;
        end else if (ce && apb_wr && paddr == OFF_IRQ_MASK) begin
            irq_mask_r <= pwdata[IRQ_W-1:0];
        end
    end

    assign irq_event[IRQ_WDT] = wdt_timeout;
    assign irq_event[IRQ_OST] = ost_done;
    assign irq_event[IRQ_WAKE] = wake_fire;

    // One flop per event; a new event beats a same-cycle write-one clear
    genvar gi;
    generate
        for (gi = 0; gi < IRQ_W; gi++) begin : g_irq
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    irq_stat_r[gi] <= 1'b0;
                end else if (ce) begin
                    if (irq_event[gi]) begin
                        irq_stat_r[gi] <= 1'b1;
                    end else if (apb_wr && paddr == OFF_IRQ_STATUS
                        && pwdata[gi]) begin
                        irq_stat_r[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Registered so the output is a clean flop; lags the status by a cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end
endmodule : cst_core_status
`default_nettype wire

// file: verification/cst_core_status_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cst_core_status_sva
    import cst_pkg::*;
#(
    parameter int WDT_BASE_CYCLES = cst_pkg::WDT_BASE_DEFAULT
) (
    input wire logic clk, // Core clock
    input wire logic reset_n, // Reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic instr_valid, // Instruction strobe
    input wire cst_op_t instr_op, // Operation
    input wire logic instr_dest_status, // Result to status
    input wire logic [7:0] operand_a, // File operand
    input wire logic watchdog_clear_instr, // Watchdog clear
    input wire logic sleep_instr, // Sleep
    input wire logic wake_event, // Wake
    input wire logic watchdog_enable_cfg, // Watchdog enable
    input wire logic [2:0] clock_mode, // Oscillator mode
    input wire logic secondary_osc, // Secondary osc clock
    input wire logic [6:0] direct_addr_lo, // Direct offset
    input wire logic [7:0] indirect_ptr, // Indirect pointer
    input wire logic [7:0] core_status, // Status
    input wire logic [7:0] alu_result, // Result
    input wire logic [8:0] direct_addr, // Direct address
    input wire logic [8:0] indirect_addr, // Indirect address
    input wire logic core_released, // Running
    input wire logic core_asleep // Asleep
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    wire logic ins_go = instr_valid && core_released;

    property p_answer;
        psel && !penable |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("ready missing");
    property p_err;
        pslverr |-> pready && psel && penable;
    endproperty
    a_err: assert property (p_err) else $error("stray error");
    property p_dir;
        1'b1 |=> direct_addr == {core_status[6:5], $past(direct_addr_lo)};
    endproperty
    a_dir: assert property (p_dir) else $error("direct address");
    property p_ind;
        1'b1 |=> indirect_addr == {core_status[7], $past(indirect_ptr)};
    endproperty
    a_ind: assert property (p_ind) else $error("indirect address");
    property p_to_rise;
        $rose(core_status[ST_TO]) |-> $past(watchdog_clear_instr || sleep_instr);
    endproperty
    a_to_rise: assert property (p_to_rise) else $error("to rose");
    property p_pd_rise;
        $rose(core_status[ST_PD]) |-> $past(watchdog_clear_instr);
    endproperty
    a_pd_rise: assert property (p_pd_rise) else $error("pd rose");
    property p_sleep;
        sleep_instr && core_released |=> core_asleep && !core_status[ST_PD];
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep entry");
    property p_zero;
        ins_go && !instr_dest_status && instr_op inside {CST_OP_ADD,
            CST_OP_SUB, CST_OP_AND, CST_OP_OR, CST_OP_XOR}
            |=> core_status[ST_Z] == (alu_result == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag");
    property p_ror;
        ins_go && instr_op == CST_OP_ROR |=> core_status[ST_C] == $past(operand_a[0]);
    endproperty
    a_ror: assert property (p_ror) else $error("rotate carry");
    property p_wdt_off;
        $fell(core_status[ST_TO]) |-> $past(watchdog_enable_cfg, 2);
    endproperty
    a_wdt_off: assert property (p_wdt_off) else $error("to fell");
    property p_ost;
        core_asleep && wake_event && !secondary_osc
            && clock_mode <= CLK_CRYSTAL_HIGH |=> !core_released [*8];
    endproperty
    a_ost: assert property (p_ost) else $error("early run");
endmodule : cst_core_status_sva

bind cst_core_status cst_core_status_sva #(
    .WDT_BASE_CYCLES(WDT_BASE_CYCLES)
) u_sva (
    .clk, .reset_n, .psel, .penable, .pready, .pslverr, .instr_valid,
    .instr_op, .instr_dest_status, .operand_a, .watchdog_clear_instr,
    .sleep_instr, .wake_event, .watchdog_enable_cfg, .clock_mode,
    .direct_addr_lo, .indirect_ptr, .core_status, .alu_result,
    .direct_addr, .indirect_addr, .core_released, .core_asleep, .secondary_osc
);
`default_nettype wire

// file: verification/test_cst_core_status.sv
`timescale 1ns/1ps
`default_nettype none
module test_cst_core_status;
    import cst_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, operand_a = 8'h00, operand_b = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rq;
    logic instr_valid = 1'b0, instr_dest_status = 1'b0, re;
    cst_op_t instr_op = CST_OP_MOVE;
    logic [2:0] ev = 3'h0, clock_mode = 3'h3;
    logic watchdog_enable_cfg = 1'b0;
    logic pready, pslverr, core_released, core_asleep, irq;
    logic [7:0] core_status, alu_result;
    logic [8:0] direct_addr, indirect_addr;
    int n_fail = 0, num_checks = 0;

    cst_core_status #(.WDT_BASE_CYCLES(8)) dut (
        .clk, .reset_n, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .instr_valid, .instr_op,
        .instr_dest_status, .operand_a, .operand_b,
        .watchdog_clear_instr(ev[2]), .sleep_instr(ev[1]),
        .wake_event(ev[0]), .watchdog_enable_cfg, .clock_mode,
        .secondary_osc(1'b0), .direct_addr_lo(7'h55),
        .indirect_ptr(8'ha5), .core_status, .alu_result, .direct_addr,
        .indirect_addr, .core_released, .core_asleep, .irq
    );

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk9(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: addr %h want %h", $time, got, exp);
        end
    endtask : chk9

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        repeat (20) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        chk8({7'h0, pready}, 8'h01);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk);
    endtask : apb

    task automatic ins(input cst_op_t op, input logic [7:0] a, b,
                       input logic ds);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_op <= op;
        operand_a <= a;
        operand_b <= b;
        instr_dest_status <= ds;
        @(posedge clk);
        instr_valid <= 1'b0;
        instr_dest_status <= 1'b0;
        @(negedge clk);
    endtask : ins

    // Bit 2 clear, bit 1 sleep, bit 0 wake
    task automatic pulse(input logic [2:0] k);
        @(posedge clk);
        ev <= k;
        @(posedge clk);
        ev <= 3'h0;
        @(negedge clk);
    endtask : pulse

    task automatic wait_run(output int n);
        n = 0;
        while (core_released !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_run

    task automatic meas(output int n);
        n = 0;
        while (core_status[ST_TO] !== 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
    endtask : meas

    task automatic ar(input cst_op_t op, input logic [7:0] a, b, r,
                      input logic [2:0] f);
        ins(op, a, b, 1'b0);
        if (op != CST_OP_ROR && op != CST_OP_ROL) begin
            chk8(alu_result, r);
        end
        chk8({5'h0, core_status[2:0]}, {5'h0, f});
    endtask : ar

    task automatic t_regs();
        apb(1'b0, OFF_STATUS, 32'h0);
        chk8(rq[7:0], 8'h18);
        apb(1'b0, OFF_OPTION, 32'h0);
        chk8(rq[7:0], 8'h0f);
        apb(1'b1, 8'h10, 32'h0);
        chk8({7'h0, re}, 8'h01);
        apb(1'b0, 8'h0e, 32'h0);
        chk8({7'h0, re}, 8'h01);
        $display("t_regs done");
    endtask : t_regs

    task automatic t_alu();
        ar(CST_OP_ADD, 8'h0f, 8'h01, 8'h10, 3'b010);
        ar(CST_OP_ADD, 8'hff, 8'h01, 8'h00, 3'b111);
        ar(CST_OP_SUB, 8'h00, 8'h01, 8'hff, 3'b000);
        ar(CST_OP_SUB, 8'h05, 8'h05, 8'h00, 3'b111);
        ar(CST_OP_SUB, 8'h10, 8'h01, 8'h0f, 3'b001);
        ar(CST_OP_ROR, 8'h01, 8'h00, 8'h00, 3'b001);
        ar(CST_OP_ROL, 8'h7f, 8'h00, 8'h00, 3'b000);
        ar(CST_OP_AND, 8'hff, 8'h00, 8'h00, 3'b100);
        ar(CST_OP_OR, 8'h00, 8'h80, 8'h80, 3'b000);
        ar(CST_OP_XOR, 8'haa, 8'h55, 8'hff, 3'b000);
        $display("t_alu done");
    endtask : t_alu

    task automatic t_status();
        apb(1'b1, OFF_STATUS, 32'he7);
        chk8(core_status, 8'hff);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, OFF_STATUS, {24'h0, k[0], k[1:0], 5'h0});
            cyc(2);
            chk9(direct_addr, {k[1:0], 7'h55});
            chk9(indirect_addr, {k[0], 8'ha5});
        end
        apb(1'b1, OFF_STATUS, 32'hff);
        ins(CST_OP_CLEAR, 8'h00, 8'h00, 1'b1);
        chk8(core_status, 8'h1f);
        ins(CST_OP_ADD, 8'he7, 8'h00, 1'b1);
        chk8(core_status, 8'hf8);
        ins(CST_OP_MOVE, 8'h00, 8'h00, 1'b1);
        chk8(core_status, 8'h18);
        $display("t_status done");
    endtask : t_status

    task automatic t_wdt();
        int n1, n2;
        apb(1'b1, OFF_OPTION, 32'h0);
        apb(1'b1, OFF_IRQ_MASK, 32'h1);
        cyc(40);
        chk8({7'h0, core_status[ST_TO]}, 8'h01);
        @(posedge clk);
        watchdog_enable_cfg <= 1'b1;
        pulse(3'h4);
        meas(n1);
        cyc(2);
        chk8({7'h0, irq}, 8'h01);
        apb(1'b1, OFF_IRQ_MASK, 32'h0);
        cyc(2);
        chk8({7'h0, irq}, 8'h00);
        @(posedge clk);
        watchdog_enable_cfg <= 1'b0;
        apb(1'b0, OFF_IRQ_STATUS, 32'h0);
        chk8({7'h0, rq[0]}, 8'h01);
        apb(1'b1, OFF_IRQ_STATUS, 32'h1);
        apb(1'b1, OFF_IRQ_MASK, 32'h1);
        apb(1'b0, OFF_IRQ_STATUS, 32'h0);
        chk8({6'h0, rq[0], irq}, 8'h00);
        apb(1'b1, OFF_OPTION, 32'h9);
        @(posedge clk);
        watchdog_enable_cfg <= 1'b1;
        pulse(3'h4);
        chk8({6'h0, core_status[4:3]}, 8'h03);
        meas(n2);
        chk8({7'h0, n1 > 4 && n1 < 13}, 8'h01);
        chk8(8'(n2 - n1), 8'h08);
        @(posedge clk);
        watchdog_enable_cfg <= 1'b0;
        $display("t_wdt done");
    endtask : t_wdt

    task automatic t_sleep();
        int n;
        pulse(3'h2);
        chk8({5'h0, core_asleep, core_status[4:3]}, 8'h06);
        pulse(3'h1);
        wait_run(n);
        chk8({7'h0, n < 4}, 8'h01);
        pulse(3'h4);
        chk8({6'h0, core_status[4:3]}, 8'h03);
        apb(1'b1, OFF_OPTION, 32'h0);
        @(posedge clk);
        clock_mode <= CLK_CRYSTAL_MEDIUM;
        watchdog_enable_cfg <= 1'b1;
        pulse(3'h4);
        pulse(3'h2);
        pulse(3'h1);
        wait_run(n);
        chk8({7'h0, n > 1022 && n < 1031}, 8'h01);
        chk8({7'h0, core_status[ST_TO]}, 8'h01);
        @(posedge clk);
        watchdog_enable_cfg <= 1'b0;
        clock_mode <= 3'h3;
        $display("t_sleep done");
    endtask : t_sleep

    initial begin
        int n;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        wait_run(n);
        t_regs();
        t_alu();
        t_status();
        t_wdt();
        t_sleep();
        tally_and_finish();
    end

    initial begin
        #100000;
        n_fail++;
        $display("unexpected at %0t: run did not finish", $time);
        tally_and_finish();
    end
endmodule : test_cst_core_status
`default_nettype wire
